// *** dv/aomcd_src_model.sv ***
/*
 * Behavioural model of what feeds the block from outside: the pll setting,
 * the charge pump flag and the audio clock measurement.
 * Assumes the bench calls its tasks and the block samples on rising clk.
 */
`timescale 1ns/100ps
`default_nettype none

module aomcd_src_model (
	// clock
	input wire logic clk,
	// sources toward the block
	output var logic pll_enabled,
	output var logic cp_valid_n,
	output var logic [2:0] rate_raw,
	output var logic [11:0] ratio_count
);
	// ***************************************************
	// source behaviour
	// ***************************************************
	// idle source: pll on, pump valid (active low), no rate seen yet
	initial begin
		pll_enabled = 1'b1;
		cp_valid_n = 1'b0;
		rate_raw = 3'h0;
		ratio_count = 12'h000;
	end

	// changes land on the falling edge, clear of the sampling edge;
	// the count is then held steady because the block only double-flops it
	task automatic set_clock(input logic [2:0] r, input logic [11:0] c, input logic p);
		@(negedge clk);
		rate_raw = r;
		ratio_count = c;
		pll_enabled = p;
	endtask

	// pump flag is free to move at any time, the block synchronises it
	task automatic set_pump(input logic v);
		@(negedge clk);
		cp_valid_n = v;
	endtask
endmodule

`default_nettype wire

// *** dv/tb_aux_output_mux_clock_detect.sv ***
/*
 * Self-checking bench for the auxiliary output mux and clock detector.
 * Assumes the source model beside it and a single core clock.
 */
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; \
	$display("[FAIL] %0t got %h expected %h", $time, g, e); end end

module tb_aux_output_mux_clock_detect;
	// ***************************************************
	// signals
	// ***************************************************
	localparam logic [7:0] DIE_ID_TB = 8'h3C; // arbitrary identifier value
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic serial_data_out_pin_dir_out = 1'b0;
	logic ce = 1'b1;
	logic [3:0] mute_src_sel = 4'h0;
	logic [7:0] reg_rdata;
	logic reg_rvalid, pin_o, pin_oe, mute_o, clock_error;
	logic pll_enabled, cp_valid_n;
	logic [2:0] rate_raw;
	logic [11:0] ratio_count;
	int failures = 0;
	int num_checks = 0;
	int ratios [14] = '{32, 48, 64, 128, 192, 256, 384, 512, 768, 1024, 1152, 1536, 2048, 3072};

	always #2 clk = ~clk;

	aomcd_top #(.DIE_ID(DIE_ID_TB), .MIN_RATIO_NO_PLL(256)) dut (.clk(clk), .rst(rst), .ce(ce),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .serial_data_out_pin_dir_out(serial_data_out_pin_dir_out),
		.mute_src_sel(mute_src_sel), .pll_enabled(pll_enabled), .cp_valid_n(cp_valid_n),
		.rate_raw(rate_raw), .ratio_count(ratio_count), .serial_data_out_pin_o(pin_o),
		.serial_data_out_pin_oe(pin_oe), .mute_pin_o(mute_o), .clock_error(clock_error));

	aomcd_src_model src (.clk(clk), .pll_enabled(pll_enabled), .cp_valid_n(cp_valid_n),
		.rate_raw(rate_raw), .ratio_count(ratio_count));

	// ***************************************************
	// bus and pin helpers
	// ***************************************************
	// one-cycle write strobe, dropped on the next falling edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask

	// answer is looked at in the one cycle it stands
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge clk);
		reg_rd = 1'b0;
		`CHK(reg_rvalid, 1'b1)
		`CHK(reg_rdata, e)
	endtask

	// waits past the three-edge pump path before looking at the pins
	task automatic pin_chk(input logic o, input logic oe, input logic m);
		repeat (4) @(negedge clk);
		`CHK(pin_o, o)
		`CHK(pin_oe, oe)
		`CHK(mute_o, m)
	endtask

	// ***************************************************
	// scenarios
	// ***************************************************
	// reset values, read-only places, reserved bits and an unmapped offset
	task automatic t_regs;
		rd_chk(8'h55, 8'h00);
		rd_chk(8'h5B, 8'h00);
		wr(8'h55, 8'hFF);
		rd_chk(8'h55, 8'h1F);
		wr(8'h56, 8'hFF);
		rd_chk(8'h56, 8'h30);
		wr(8'h57, 8'hFF);
		rd_chk(8'h57, 8'h30);
		wr(8'h58, 8'h00);
		rd_chk(8'h58, DIE_ID_TB);
		wr(8'h5B, 8'hFF);
		rd_chk(8'h5B, 8'h00);
		wr(8'h60, 8'hFF);
		rd_chk(8'h60, 8'h00);
		wr(8'h55, 8'h00);
		wr(8'h56, 8'h00);
		wr(8'h57, 8'h00);
	endtask

	// serial out: software level, inversion, pump flag, undefined code, direction
	task automatic t_serial_data_out_pin;
		serial_data_out_pin_dir_out = 1'b1;
		wr(8'h55, 8'h02);
		pin_chk(1'b0, 1'b1, 1'b0);
		wr(8'h56, 8'h20);
		pin_chk(1'b1, 1'b1, 1'b0);
		wr(8'h57, 8'h20);
		pin_chk(1'b0, 1'b1, 1'b0);
		wr(8'h57, 8'h00);
		wr(8'h55, 8'h1B);
		pin_chk(1'b0, 1'b1, 1'b0);
		src.set_pump(1'b1);
		pin_chk(1'b1, 1'b1, 1'b0);
		wr(8'h55, 8'h05);
		pin_chk(1'b0, 1'b1, 1'b0);
		wr(8'h57, 8'h20);
		pin_chk(1'b1, 1'b1, 1'b0);
		serial_data_out_pin_dir_out = 1'b0;
		pin_chk(1'b0, 1'b0, 1'b0);
	endtask

	// mute pin: register source, inversion, and a source the block does not honour
	task automatic t_mute;
		mute_src_sel = 4'h2;
		wr(8'h56, 8'h10);
		pin_chk(1'b0, 1'b0, 1'b1);
		wr(8'h57, 8'h10);
		pin_chk(1'b0, 1'b0, 1'b0);
		mute_src_sel = 4'h3;
		pin_chk(1'b0, 1'b0, 1'b1);
	endtask

	// clock enable low: a write is dropped and a mute source change waits for it
	task automatic t_freeze;
		@(negedge clk);
		ce = 1'b0;
		mute_src_sel = 4'h2;
		wr(8'h56, 8'h00);
		pin_chk(1'b0, 1'b0, 1'b1);
		@(negedge clk);
		ce = 1'b1;
		pin_chk(1'b0, 1'b0, 1'b0);
		rd_chk(8'h56, 8'h10);
	endtask

	// every ratio code, every rate class, then invalid and pll-off cases
	task automatic t_detect;
		for (int i = 0; i < 14; i++) begin
			src.set_clock(3'h3, 12'(ratios[i]), 1'b1);
			repeat (6) @(negedge clk);
			rd_chk(8'h5B, {4'h3, 4'(i + 1)});
			`CHK(clock_error, 1'b0)
		end
		for (int r = 0; r < 8; r++) begin
			src.set_clock(3'(r), 12'd256, 1'b1);
			repeat (6) @(negedge clk);
			rd_chk(8'h5B, {1'b0, (r == 7) ? 3'h0 : 3'(r), 4'h6});
			`CHK(clock_error, (r == 0 || r == 7))
		end
		src.set_clock(3'h3, 12'd100, 1'b1);
		repeat (6) @(negedge clk);
		rd_chk(8'h5B, 8'h30);
		`CHK(clock_error, 1'b1)
		src.set_clock(3'h3, 12'd128, 1'b0);
		repeat (6) @(negedge clk);
		rd_chk(8'h5B, 8'h34);
		`CHK(clock_error, 1'b1)
		src.set_clock(3'h3, 12'd512, 1'b0);
		repeat (6) @(negedge clk);
		`CHK(clock_error, 1'b0)
	endtask

	// ***************************************************
	// run control
	// ***************************************************
	task automatic finish_test;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// watchdog: the whole sequence needs well under two thousand cycles
	initial begin
		#40000;
		failures++;
		finish_test();
	end

	initial begin
		repeat (6) @(negedge clk);
		rst = 1'b0;
		t_regs();
		t_serial_data_out_pin();
		t_mute();
		t_freeze();
		t_detect();
		finish_test();
	end
endmodule

`default_nettype wire

// *** src/aomcd_det_if.sv ***
/*
 * Holds the interface that joins the register block to the clock detector.
 * Assumes both ends run on the same core clock.
 */
`timescale 1ns/100ps
`default_nettype none

interface aomcd_det_if;
	logic [2:0] rate_raw;
	aomcd_pkg::aomcd_count_type ratio_count;
	logic pll_enabled;
	logic [2:0] rate_class;
	logic [3:0] ratio_code;
	logic clock_error;
	modport regs (output rate_raw, output ratio_count, output pll_enabled,
		input rate_class, input ratio_code, input clock_error);
	modport det (input rate_raw, input ratio_count, input pll_enabled,
		output rate_class, output ratio_code, output clock_error);
endinterface

`default_nettype wire

// *** src/aomcd_detect.sv ***
/*
 * Holds the clock detector classifier: turns a measured master clock count per
 * sample and a raw sample rate class into the reported codes and an error flag.
 * Assumes its inputs are already synchronised to the core clock.
 */
`timescale 1ns/100ps
`default_nettype none
`include "aomcd_params.svh"

module aomcd_detect #(
	parameter int MIN_RATIO_NO_PLL = 256
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// link to register block
	aomcd_det_if.det det
);
	logic [2:0] rate_reg, rate_next;
	logic [3:0] code_reg, code_next;
	logic err_reg, err_next;

	// ***************************************************
	// ratio decoding
	// ***************************************************
	// anything not in the ascending table is a disallowed ratio
	function automatic logic [3:0] ratio_to_code(input aomcd_pkg::aomcd_count_type n);
		case (n)
			12'd32: ratio_to_code = 4'h1;
			12'd48: ratio_to_code = 4'h2;
			12'd64: ratio_to_code = 4'h3;
			12'd128: ratio_to_code = 4'h4;
			12'd192: ratio_to_code = 4'h5;
			12'd256: ratio_to_code = 4'h6;
			12'd384: ratio_to_code = 4'h7;
			12'd512: ratio_to_code = 4'h8;
			12'd768: ratio_to_code = 4'h9;
			12'd1024: ratio_to_code = 4'hA;
			12'd1152: ratio_to_code = 4'hB;
			12'd1536: ratio_to_code = 4'hC;
			12'd2048: ratio_to_code = 4'hD;
			12'd3072: ratio_to_code = 4'hE;
			default: ratio_to_code = `AOMCD_RATIO_ERR;
		endcase
	endfunction

	// classify; a valid ratio can still be an error when too slow without the pll
	always_comb begin
		rate_next = det.rate_raw;
		if (det.rate_raw > `AOMCD_RATE_MAX) begin
			rate_next = `AOMCD_RATE_ERR;
		end
		code_next = ratio_to_code(det.ratio_count);
		err_next = (code_next == `AOMCD_RATIO_ERR) || (rate_next == `AOMCD_RATE_ERR)
			|| (!det.pll_enabled && (det.ratio_count < 12'(MIN_RATIO_NO_PLL)));
		if (!ce) begin
			rate_next = rate_reg;
			code_next = code_reg;
			err_next = err_reg;
		end
	end

	// register the codes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rate_reg <= `AOMCD_RATE_ERR;
			code_reg <= `AOMCD_RATIO_ERR;
			err_reg <= 1'b0;
		end else begin
			rate_reg <= rate_next;
			code_reg <= code_next;
			err_reg <= err_next;
		end
	end

	assign det.rate_class = rate_reg;
	assign det.ratio_code = code_reg;
	assign det.clock_error = err_reg;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_ratio_256_code: assert property (ce && det.ratio_count == 12'd256
		|=> det.ratio_code == 4'h6) else $error("ratio 256 not coded 0110");
	a_ratio_bad_err: assert property (ce && det.ratio_count == 12'd100
		|=> det.ratio_code == 4'h0 && det.clock_error) else $error("bad ratio not flagged");
	a_rate_pass: assert property (ce && det.rate_raw == 3'h3
		|=> det.rate_class == 3'h3) else $error("rate class not passed");
	a_slow_noPll_err: assert property (ce && !det.pll_enabled && det.ratio_count == 12'd64
		|=> det.ratio_code == 4'h3 && det.clock_error) else $error("slow ratio not flagged");
endmodule

`default_nettype wire

// *** src/aomcd_params.svh ***
/*
 * Holds the register offsets, field positions, reset values and fixed codes of the
 * auxiliary output mux and clock detector.
 * Assumes it is included by bare name by every file that needs these constants.
 */
`ifndef AOMCD_PARAMS_SVH
`define AOMCD_PARAMS_SVH

// ***************************************************
// register offsets
// ***************************************************
`define AOMCD_OFS_SRC_SEL 8'h55
`define AOMCD_OFS_SW_DRIVE 8'h56
`define AOMCD_OFS_POLARITY 8'h57
`define AOMCD_OFS_DIE_ID 8'h58
`define AOMCD_OFS_RATE_RATIO 8'h5B

// ***************************************************
// field positions and reset values
// ***************************************************
`define AOMCD_SEL_MSB 4
`define AOMCD_SERIAL_DATA_OUT_PIN_BIT 5
`define AOMCD_MUTE_BIT 4
`define AOMCD_RATE_MSB 6
`define AOMCD_RATE_LSB 4
`define AOMCD_RATIO_MSB 3
`define AOMCD_RST_BYTE 8'h00
`define AOMCD_RST_SEL 5'h00

// ***************************************************
// fixed codes
// ***************************************************
`define AOMCD_MUTE_SRC_REG 4'h2
`define AOMCD_RATE_ERR 3'h0
`define AOMCD_RATE_MAX 3'h6
`define AOMCD_RATIO_ERR 4'h0

`endif

// *** src/aomcd_pkg.sv ***
/*
 * Holds the types shared by the auxiliary output mux and its clock detector.
 * Assumes nothing of its surroundings beyond a SystemVerilog compiler.
 */
package aomcd_pkg;
	typedef logic [7:0] aomcd_byte_type;
	typedef logic [11:0] aomcd_count_type;
	// serial data out source codes with a defined meaning
	typedef enum logic [4:0] {
		AOMCD_SRC_REG_LEVEL = 5'b00010,
		AOMCD_SRC_CP_VALID_N = 5'b11011
	} aomcd_src_type;
endpackage

// *** src/aomcd_top.sv ***
/*
 * Holds the auxiliary output registers, the serial data out and mute pin muxes
 * and the status read-back of the clock detector.
 * Assumes a byte-wide register port driven by the control bus front end on clk,
 * and detector and charge pump inputs that arrive from other clock domains.
 */
`timescale 1ns/100ps
`default_nettype none
`include "aomcd_params.svh"

// How it works
// - a five-bit select chooses the source driven onto the serial data out pin
// - the pin carries the selection only while its direction is set to output
// - code 11011 routes the active-low charge pump voltage valid flag
// - undefined select codes give a constant zero
// - register-output code drives the serial out pin from a software level bit
// - mute register-output code drives the mute pin from a software level bit
// - serial out polarity bit inverts its selected signal when one
// - mute polarity bit inverts its selected signal when one
// - three-bit read-only sample rate class, zero meaning out of range
// - four-bit read-only master clock to sample rate ratio code
// - a valid ratio may still raise clock error when the rate class is zero, or below MIN_RATIO_NO_PLL with the pll off
// - ratio code zero is disallowed; codes one upward map 32 to 3072
module aomcd_top #(
	parameter logic [7:0] DIE_ID = 8'h5A, // arbitrary identifier value
	parameter int MIN_RATIO_NO_PLL = 256
) (
	// clock, reset, enable
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	// settings held elsewhere in the device
	input wire logic serial_data_out_pin_dir_out,
	input wire logic [3:0] mute_src_sel,
	input wire logic pll_enabled,
	// asynchronous sources
	input wire logic cp_valid_n,
	input wire logic [2:0] rate_raw,
	input wire logic [11:0] ratio_count,
	// pins
	output logic serial_data_out_pin_o,
	output logic serial_data_out_pin_oe,
	output logic mute_pin_o,
	output logic clock_error
);
	aomcd_det_if det_link();

	logic [4:0] sel_reg, sel_next;
	logic sw_serial_data_out_pin_reg, sw_serial_data_out_pin_next, sw_mute_reg, sw_mute_next;
	logic inv_serial_data_out_pin_reg, inv_serial_data_out_pin_next, inv_mute_reg, inv_mute_next;
	logic [7:0] rdata_reg, rdata_next;
	logic rvalid_reg, rvalid_next;
	logic pin_reg, pin_next, oe_reg, oe_next, mute_reg, mute_next, err_reg, err_next;
	logic cp_s1_reg, cp_s2_reg;
	logic [2:0] rate_s1_reg, rate_s2_reg;
	logic [11:0] cnt_s1_reg, cnt_s2_reg;
	logic serial_data_out_pin_sel_sig;

	// ***************************************************
	// input synchronisers
	// ***************************************************
	// the count is assumed quasi-static; a change mid-sample is seen as one bad reading
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cp_s1_reg <= 1'b1;
			cp_s2_reg <= 1'b1;
			rate_s1_reg <= `AOMCD_RATE_ERR;
			rate_s2_reg <= `AOMCD_RATE_ERR;
			cnt_s1_reg <= 12'h000;
			cnt_s2_reg <= 12'h000;
		end else if (ce) begin
			cp_s1_reg <= cp_valid_n;
			cp_s2_reg <= cp_s1_reg;
			rate_s1_reg <= rate_raw;
			rate_s2_reg <= rate_s1_reg;
			cnt_s1_reg <= ratio_count;
			cnt_s2_reg <= cnt_s1_reg;
		end
	end

	assign det_link.rate_raw = rate_s2_reg;
	assign det_link.ratio_count = cnt_s2_reg;
	assign det_link.pll_enabled = pll_enabled;

	aomcd_detect #(
		.MIN_RATIO_NO_PLL(MIN_RATIO_NO_PLL)
	) u_detect (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.det(det_link)
	);

	// ***************************************************
	// register file
	// ***************************************************
	// writes store only defined fields; reserved bits read back as zero
	always_comb begin
		sel_next = sel_reg;
		sw_serial_data_out_pin_next = sw_serial_data_out_pin_reg;
		sw_mute_next = sw_mute_reg;
		inv_serial_data_out_pin_next = inv_serial_data_out_pin_reg;
		inv_mute_next = inv_mute_reg;
		rvalid_next = ce ? reg_rd : rvalid_reg;
		rdata_next = rdata_reg;
		if (ce && reg_wr) begin
			case (reg_addr)
				`AOMCD_OFS_SRC_SEL: sel_next = reg_wdata[`AOMCD_SEL_MSB:0];
				`AOMCD_OFS_SW_DRIVE: begin
					sw_serial_data_out_pin_next = reg_wdata[`AOMCD_SERIAL_DATA_OUT_PIN_BIT];
					sw_mute_next = reg_wdata[`AOMCD_MUTE_BIT];
				end
				`AOMCD_OFS_POLARITY: begin
					inv_serial_data_out_pin_next = reg_wdata[`AOMCD_SERIAL_DATA_OUT_PIN_BIT];
					inv_mute_next = reg_wdata[`AOMCD_MUTE_BIT];
				end
				default: ;
			endcase
		end
		if (ce && reg_rd) begin
			rdata_next = `AOMCD_RST_BYTE;
			case (reg_addr)
				`AOMCD_OFS_SRC_SEL: rdata_next[`AOMCD_SEL_MSB:0] = sel_reg;
				`AOMCD_OFS_SW_DRIVE: begin
					rdata_next[`AOMCD_SERIAL_DATA_OUT_PIN_BIT] = sw_serial_data_out_pin_reg;
					rdata_next[`AOMCD_MUTE_BIT] = sw_mute_reg;
				end
				`AOMCD_OFS_POLARITY: begin
					rdata_next[`AOMCD_SERIAL_DATA_OUT_PIN_BIT] = inv_serial_data_out_pin_reg;
					rdata_next[`AOMCD_MUTE_BIT] = inv_mute_reg;
				end
				`AOMCD_OFS_DIE_ID: rdata_next = DIE_ID;
				`AOMCD_OFS_RATE_RATIO: begin
					rdata_next[`AOMCD_RATE_MSB:`AOMCD_RATE_LSB] = det_link.rate_class;
					rdata_next[`AOMCD_RATIO_MSB:0] = det_link.ratio_code;
				end
				default: rdata_next = `AOMCD_RST_BYTE;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sel_reg <= `AOMCD_RST_SEL;
			sw_serial_data_out_pin_reg <= 1'b0;
			sw_mute_reg <= 1'b0;
			inv_serial_data_out_pin_reg <= 1'b0;
			inv_mute_reg <= 1'b0;
			rdata_reg <= `AOMCD_RST_BYTE;
			rvalid_reg <= 1'b0;
		end else begin
			sel_reg <= sel_next;
			sw_serial_data_out_pin_reg <= sw_serial_data_out_pin_next;
			sw_mute_reg <= sw_mute_next;
			inv_serial_data_out_pin_reg <= inv_serial_data_out_pin_next;
			inv_mute_reg <= inv_mute_next;
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	// ***************************************************
	// pin muxes
	// ***************************************************
	// source selection for the serial data out pin
	always_comb begin
		case (sel_reg)
			aomcd_pkg::AOMCD_SRC_REG_LEVEL: serial_data_out_pin_sel_sig = sw_serial_data_out_pin_reg;
			aomcd_pkg::AOMCD_SRC_CP_VALID_N: serial_data_out_pin_sel_sig = cp_s2_reg;
			default: serial_data_out_pin_sel_sig = 1'b0;
		endcase
	end

	// polarity is applied after selection, so even a constant zero can be inverted
	always_comb begin
		pin_next = pin_reg;
		oe_next = oe_reg;
		mute_next = mute_reg;
		err_next = err_reg;
		if (ce) begin
			oe_next = serial_data_out_pin_dir_out;
			pin_next = serial_data_out_pin_dir_out & (serial_data_out_pin_sel_sig ^ inv_serial_data_out_pin_reg);
			mute_next = ((mute_src_sel == `AOMCD_MUTE_SRC_REG) & sw_mute_reg) ^ inv_mute_reg;
			err_next = det_link.clock_error;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_reg <= 1'b0;
			oe_reg <= 1'b0;
			mute_reg <= 1'b0;
			err_reg <= 1'b0;
		end else begin
			pin_reg <= pin_next;
			oe_reg <= oe_next;
			mute_reg <= mute_next;
			err_reg <= err_next;
		end
	end

	assign reg_rdata = rdata_reg;
	assign reg_rvalid = rvalid_reg;
	assign serial_data_out_pin_o = pin_reg;
	assign serial_data_out_pin_oe = oe_reg;
	assign mute_pin_o = mute_reg;
	assign clock_error = err_reg;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// the bench always leaves one idle cycle between a write and the read behind it
	a_sel_write_read: assert property (
		ce && reg_wr && reg_addr == 8'h55 ##1 ce && !reg_wr
		##1 ce && reg_rd && reg_addr == 8'h55 && !reg_wr
		|=> reg_rdata == ($past(reg_wdata, 3) & 8'h1F) && reg_rvalid)
		else $error("select readback wrong");
	a_dir_gates_pin: assert property (ce && !serial_data_out_pin_dir_out
		|=> !serial_data_out_pin_oe && !serial_data_out_pin_o) else $error("pin driven as input");
	a_cp_flag_route: assert property (ce && serial_data_out_pin_dir_out && sel_reg == 5'h1B && !inv_serial_data_out_pin_reg
		|=> serial_data_out_pin_o == $past(cp_s2_reg)) else $error("charge pump flag not routed");
	a_undef_zero: assert property (
		ce && serial_data_out_pin_dir_out && sel_reg != 5'h02 && sel_reg != 5'h1B && !inv_serial_data_out_pin_reg
		|=> !serial_data_out_pin_o) else $error("undefined code not zero");
	a_sw_level_out: assert property (ce && serial_data_out_pin_dir_out && sel_reg == 5'h02
		|=> serial_data_out_pin_o == ($past(sw_serial_data_out_pin_reg) ^ $past(inv_serial_data_out_pin_reg)))
		else $error("software level not driven");
	a_mute_sw_level: assert property (ce && mute_src_sel == 4'h2
		|=> mute_pin_o == ($past(sw_mute_reg) ^ $past(inv_mute_reg))) else $error("mute level wrong");
	a_mute_inv_zero: assert property (ce && mute_src_sel != 4'h2 && inv_mute_reg
		|=> mute_pin_o) else $error("mute inversion missing");
	a_status_read: assert property (ce && reg_rd && reg_addr == 8'h5B
		|=> reg_rdata[7] == 1'b0 && reg_rdata[6:4] == $past(det_link.rate_class)
		&& reg_rdata[3:0] == $past(det_link.ratio_code)) else $error("status read wrong");
	a_die_id_read: assert property (ce && reg_rd && reg_addr == 8'h58
		|=> reg_rdata == DIE_ID) else $error("die id read wrong");
	a_err_follow: assert property (ce |=> clock_error == $past(det_link.clock_error))
		else $error("clock error not forwarded");
endmodule

`default_nettype wire
